/* verilog/phy_frame_check_and_generate.sv */
// Frame checker counters and frame generator with an Avalon-MM register slave
// Summary of operation
// - Count received frames longer than 1522 bytes; snapshot readable.
// - Count received frames shorter than 64 bytes; snapshot readable.
// - Count received frames with an odd nibble count; snapshot readable.
// - Count packets whose preamble has an odd nibble count; snapshot readable.
// - Count each cycle that bad_ssd is high as false carrier.
// - Reading the error tally copies every checker counter in one cycle.
// - Each error copy is a 16-bit read-only value, the frame count copy 32-bit; zero after reset.
// - Enable bit routes generator frames instead of MAC data; resets to 0.
// - Writing 1 to bit 3 restarts the generator; the bit self-clears.
// - Pattern 000 stops frames after the current frame completes.
// - Pattern 001 random, 010 zeros, 011 ones, 100 0x55; reset 001.
// - Pattern 101 fills payload counting down from 255 to 0.
// - Continuous bit set: frames repeat without limit while enabled.
// - Continuous bit clear (reset): one burst of programmed frames, then stop.
// - Burst count is 32 bits in two halves, reset 0x100, used per start.
// - Done flag stays high until read or a new start; raises interrupt when enabled.
// - Payload length programmable, reset 0x6B; header and FCS add 18 bytes.
// - Programmable interframe gap in bytes, reset 0xC, between frames.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
module phy_frame_check_and_generate
  import phy_fcg_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire av_req_t av_req,
  output logic [15:0] av_readdata,
  output logic av_waitrequest,
  input wire rx_nibble_t rx_in,
  input wire tx_byte_t mac_tx,
  output tx_byte_t phy_tx,
  output logic gen_irq
);
  typedef enum {G_IDLE, G_PRE, G_HDR, G_PAY, G_FCS, G_GAP} gen_state_t;
  typedef enum {RX_IDLE, RX_PRE, RX_DATA} rx_state_t;

  function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic hit);
    sat_inc = (hit && v != CNT_MAX) ? v + 16'h0001 : v;
  endfunction

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    crc_byte = r;
  endfunction

  // Register bus: one wait state, side effects at the taking edge
  logic ack;
  logic next_ack;
  logic take;
  logic rd_take;
  logic wr_take;
  logic [15:0] next_readdata;
  assign take = (av_req.read || av_req.write) && !ack;
  assign rd_take = take && av_req.read;
  assign wr_take = take && av_req.write;
  assign av_waitrequest = (av_req.read || av_req.write) && !ack;

  // Software state
  logic gen_enable;
  logic next_gen_enable;
  logic [2:0] pattern;
  logic [2:0] next_pattern;
  logic cont_mode;
  logic next_cont_mode;
  logic irq_en;
  logic next_irq_en;
  logic diag_clk_en;
  logic next_diag_clk_en;
  logic [15:0] pay_len;
  logic [15:0] next_pay_len;
  logic [15:0] ifg_len;
  logic [15:0] next_ifg_len;
  logic [31:0] nfrm;
  logic [31:0] next_nfrm;
  logic restart;
  logic tally_read;
  logic done_read;

  // Checker state
  rx_state_t rx_state;
  rx_state_t next_rx_state;
  logic [15:0] pre_nib;
  logic [15:0] next_pre_nib;
  logic [15:0] dat_nib;
  logic [15:0] next_dat_nib;
  logic [NUM_ERR-1:0] ev;
  logic [15:0] cnt [NUM_ERR];
  logic [15:0] next_cnt [NUM_ERR];
  logic [15:0] snap [NUM_ERR];
  logic [15:0] next_snap [NUM_ERR];
  logic [31:0] frm_cnt;
  logic [31:0] next_frm_cnt;
  logic [31:0] frm_snap;
  logic [31:0] next_frm_snap;
  logic [15:0] tally;
  logic [15:0] next_tally;
  logic frame_end;

  // Generator state
  gen_state_t gstate;
  gen_state_t next_gstate;
  logic [15:0] gidx;
  logic [15:0] next_gidx;
  logic [31:0] remain;
  logic [31:0] next_remain;
  logic [31:0] crc;
  logic [31:0] next_crc;
  logic done;
  logic next_done;
  logic [5:0] div;
  logic [5:0] next_div;
  logic tick;
  logic start;
  logic gen_done_set;
  logic pay_start;
  logic pay_adv;
  logic [7:0] pay_byte;
  logic [7:0] cur_byte;
  tx_byte_t next_phy_tx;

  assign restart = wr_take && av_req.address == REG_GEN_CTRL
    && av_req.writedata[RESTART_BIT];
  assign tally_read = rd_take && av_req.address == REG_RX_ERR;
  assign done_read = rd_take && av_req.address == REG_DONE;
  assign start = restart || (gen_enable == 1'b0 && next_gen_enable);
  assign gen_irq = done && irq_en;

  always_comb begin
    next_ack = take;
    next_gen_enable = gen_enable;
    next_pattern = pattern;
    next_cont_mode = cont_mode;
    next_irq_en = irq_en;
    next_diag_clk_en = diag_clk_en;
    next_pay_len = pay_len;
    next_ifg_len = ifg_len;
    next_nfrm = nfrm;
    if (wr_take) begin
      case (av_req.address)
        REG_GEN_EN: next_gen_enable = av_req.writedata[0];
        REG_GEN_CTRL: next_pattern = av_req.writedata[2:0];
        REG_GEN_CONT: next_cont_mode = av_req.writedata[0];
        REG_GEN_IRQ_EN: next_irq_en = av_req.writedata[0];
        REG_DIAG_CLK: next_diag_clk_en = av_req.writedata[0];
        REG_PAY_LEN: next_pay_len = av_req.writedata;
        REG_IFG: next_ifg_len = av_req.writedata;
        REG_NFRM_H: next_nfrm = {av_req.writedata, nfrm[15:0]};
        REG_NFRM_L: next_nfrm = {nfrm[31:16], av_req.writedata};
        default: next_nfrm = nfrm;
      endcase
    end
    next_readdata = av_readdata;
    if (rd_take) begin
      case (av_req.address)
        REG_RX_ERR: next_readdata = tally;
        REG_FRM_H: next_readdata = frm_snap[31:16];
        REG_FRM_L: next_readdata = frm_snap[15:0];
        REG_OSZ: next_readdata = snap[0];
        REG_USZ: next_readdata = snap[1];
        REG_ODD: next_readdata = snap[2];
        REG_ODD_PRE: next_readdata = snap[3];
        REG_FALSE_CAR: next_readdata = snap[4];
        REG_GEN_EN: next_readdata = {15'h0000, gen_enable};
        REG_GEN_CTRL: next_readdata = {13'h0000, pattern};
        REG_GEN_CONT: next_readdata = {15'h0000, cont_mode};
        REG_GEN_IRQ_EN: next_readdata = {15'h0000, irq_en};
        REG_DIAG_CLK: next_readdata = {15'h0000, diag_clk_en};
        REG_PAY_LEN: next_readdata = pay_len;
        REG_IFG: next_readdata = ifg_len;
        REG_NFRM_H: next_readdata = nfrm[31:16];
        REG_NFRM_L: next_readdata = nfrm[15:0];
        REG_DONE: next_readdata = {15'h0000, done};
        default: next_readdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack <= 1'b0;
      av_readdata <= 16'h0000;
      gen_enable <= 1'b0;
      pattern <= PATTERN_RST;
      cont_mode <= 1'b0;
      irq_en <= 1'b0;
      diag_clk_en <= 1'b0;
      pay_len <= PAY_LEN_RST;
      ifg_len <= IFG_RST;
      nfrm <= NFRM_RST;
    end else begin
      ack <= next_ack;
      av_readdata <= next_readdata;
      gen_enable <= next_gen_enable;
      pattern <= next_pattern;
      cont_mode <= next_cont_mode;
      irq_en <= next_irq_en;
      diag_clk_en <= next_diag_clk_en;
      pay_len <= next_pay_len;
      ifg_len <= next_ifg_len;
      nfrm <= next_nfrm;
    end
  end

  // Frame checker
  always_comb begin
    next_rx_state = rx_state;
    next_pre_nib = pre_nib;
    next_dat_nib = dat_nib;
    ev = '0;
    frame_end = 1'b0;
    ev[4] = rx_in.bad_ssd;
    case (rx_state)
      RX_IDLE: begin
        if (rx_in.dv) begin
          next_pre_nib = 16'h0001;
          next_rx_state = (rx_in.nibble == SFD_NIBBLE) ? RX_DATA : RX_PRE;
          next_dat_nib = 16'h0000;
          ev[3] = (rx_in.nibble == SFD_NIBBLE);
        end
      end
      RX_PRE: begin
        if (!rx_in.dv) begin
          next_rx_state = RX_IDLE;
        end else begin
          next_pre_nib = sat_inc(pre_nib, 1'b1);
          if (rx_in.nibble == SFD_NIBBLE) begin
            next_rx_state = RX_DATA;
            ev[3] = !pre_nib[0];
          end
        end
      end
      RX_DATA: begin
        if (rx_in.dv) begin
          next_dat_nib = sat_inc(dat_nib, 1'b1);
        end else begin
          next_rx_state = RX_IDLE;
          frame_end = 1'b1;
          ev[0] = {1'b0, dat_nib[15:1]} > OVERSIZE_BYTES;
          ev[1] = {1'b0, dat_nib[15:1]} < UNDERSIZE_BYTES;
          ev[2] = dat_nib[0];
        end
      end
      default: next_rx_state = RX_IDLE;
    endcase
    for (int i = 0; i < NUM_ERR; i++) begin
      next_cnt[i] = sat_inc(cnt[i], ev[i]);
      next_snap[i] = tally_read ? cnt[i] : snap[i];
    end
    next_frm_cnt = frm_cnt + {31'h0, frame_end};
    next_frm_snap = tally_read ? frm_cnt : frm_snap;
    next_tally = sat_inc(tally_read ? 16'h0000 : tally, |ev);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_state <= RX_IDLE;
      pre_nib <= 16'h0000;
      dat_nib <= 16'h0000;
      frm_cnt <= 32'h0000_0000;
      frm_snap <= 32'h0000_0000;
      tally <= 16'h0000;
      for (int i = 0; i < NUM_ERR; i++) begin
        cnt[i] <= SNAP_RST;
        snap[i] <= SNAP_RST;
      end
    end else begin
      rx_state <= next_rx_state;
      pre_nib <= next_pre_nib;
      dat_nib <= next_dat_nib;
      frm_cnt <= next_frm_cnt;
      frm_snap <= next_frm_snap;
      tally <= next_tally;
      for (int i = 0; i < NUM_ERR; i++) begin
        cnt[i] <= next_cnt[i];
        snap[i] <= next_snap[i];
      end
    end
  end

  // Frame generator: one byte per tick, ticks only with the diagnostic clock on
  assign tick = (div == 6'h00) && diag_clk_en;
  assign pay_start = tick && gstate == G_HDR && gidx == HEADER_LAST;
  assign pay_adv = tick && gstate == G_PAY;

  payload_pattern_source u_pattern (
    .clk(clk),
    .rstn(rstn),
    .frame_start(pay_start),
    .advance(pay_adv),
    .pattern(pattern),
    .pay_byte(pay_byte)
  );

  always_comb begin
    case (gstate)
      G_PRE: cur_byte = (gidx == PREAMBLE_LAST) ? SFD_BYTE : PREAMBLE_BYTE;
      G_HDR: begin
        if (gidx <= DEST_LAST) begin
          cur_byte = DEST_BYTE;
        end else if (gidx <= SRC_LAST) begin
          cur_byte = SRC_BYTE;
        end else begin
          cur_byte = (gidx == LEN_HI_IDX) ? pay_len[15:8] : pay_len[7:0];
        end
      end
      G_PAY: cur_byte = pay_byte;
      G_FCS: cur_byte = 8'(~crc >> {gidx[1:0], 3'b000});
      default: cur_byte = BYTE_ZEROS;
    endcase
  end

  always_comb begin
    next_div = (div == BYTE_CYCLES - 6'h01) ? 6'h00 : div + 6'h01;
    next_gstate = gstate;
    next_gidx = gidx;
    next_remain = remain;
    next_crc = crc;
    gen_done_set = 1'b0;
    if (tick && (gstate == G_HDR || gstate == G_PAY)) begin
      next_crc = crc_byte(crc, cur_byte);
    end
    if (tick) begin
      case (gstate)
        G_PRE: begin
          next_gidx = gidx + 16'h0001;
          if (gidx == PREAMBLE_LAST) begin
            next_gstate = G_HDR;
            next_gidx = 16'h0000;
            next_crc = CRC_INIT;
          end
        end
        G_HDR: begin
          next_gidx = gidx + 16'h0001;
          if (gidx == HEADER_LAST) begin
            next_gstate = (pay_len == 16'h0000) ? G_FCS : G_PAY;
            next_gidx = 16'h0000;
          end
        end
        G_PAY: begin
          next_gidx = gidx + 16'h0001;
          if (gidx == pay_len - 16'h0001) begin
            next_gstate = G_FCS;
            next_gidx = 16'h0000;
          end
        end
        G_FCS: begin
          next_gidx = gidx + 16'h0001;
          if (gidx == FCS_LAST) begin
            next_gidx = 16'h0000;
            next_remain = remain - 32'h0000_0001;
            if (!cont_mode && remain == 32'h0000_0001) begin
              next_gstate = G_IDLE;
              gen_done_set = 1'b1;
            end else if (pattern == PAT_STOP) begin
              next_gstate = G_IDLE;
            end else begin
              next_gstate = (ifg_len == 16'h0000) ? G_PRE : G_GAP;
            end
          end
        end
        G_GAP: begin
          next_gidx = gidx + 16'h0001;
          if (gidx >= ifg_len - 16'h0001) begin
            next_gidx = 16'h0000;
            next_gstate = (pattern == PAT_STOP) ? G_IDLE : G_PRE;
          end
        end
        default: next_gstate = G_IDLE;
      endcase
    end
    if (start) begin
      next_remain = nfrm;
      next_gidx = 16'h0000;
      next_gstate = G_IDLE;
      if (pattern != PAT_STOP && (cont_mode || nfrm != 32'h0000_0000)) begin
        next_gstate = G_PRE;
      end
    end
    if (!next_gen_enable) begin
      next_gstate = G_IDLE;
    end
    next_done = done;
    if (done_read || start) begin
      next_done = 1'b0;
    end
    // A start in the same cycle as a burst end wins, so no stale completion survives
    if ((gen_done_set && !start)
        || (start && next_gen_enable && !cont_mode && nfrm == 32'h0000_0000)) begin
      next_done = 1'b1;
    end
    next_phy_tx = mac_tx;
    if (gen_enable) begin
      next_phy_tx = phy_tx;
      if (tick) begin
        next_phy_tx.en = gstate != G_IDLE && gstate != G_GAP;
        next_phy_tx.data = cur_byte;
      end
      if (gstate == G_IDLE) begin
        next_phy_tx.en = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div <= 6'h00;
      gstate <= G_IDLE;
      gidx <= 16'h0000;
      remain <= 32'h0000_0000;
      crc <= CRC_INIT;
      done <= 1'b0;
      phy_tx <= '0;
    end else begin
      div <= next_div;
      gstate <= next_gstate;
      gidx <= next_gidx;
      remain <= next_remain;
      crc <= next_crc;
      done <= next_done;
      phy_tx <= next_phy_tx;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence seq_frame_last_byte;
    tick && gstate == G_FCS && gidx == FCS_LAST;
  endsequence

  a_tally_snapshot: assert property (tally_read |=> snap[0] == $past(cnt[0])
    && snap[4] == $past(cnt[4]) && frm_snap == $past(frm_cnt))
    else $error("snapshot not taken on tally read");
  a_oversize_count: assert property ((frame_end && dat_nib[15:1] > OVERSIZE_BYTES
    && cnt[0] != CNT_MAX) |=> cnt[0] == $past(cnt[0]) + 16'h0001)
    else $error("oversize frame not counted");
  a_undersize_flag: assert property ((frame_end && dat_nib[15:1] < UNDERSIZE_BYTES)
    |-> ev[1] && !ev[0])
    else $error("undersize frame not flagged");
  a_false_carrier: assert property ((rx_in.bad_ssd && cnt[4] != CNT_MAX)
    |=> cnt[4] == $past(cnt[4]) + 16'h0001)
    else $error("false carrier not counted");
  a_mac_passthrough: assert property ((!gen_enable) |=> phy_tx == $past(mac_tx))
    else $error("mac data not forwarded");
  a_burst_end_done: assert property ((seq_frame_last_byte and !cont_mode
    && remain == 32'h0000_0001 && gen_enable && !start) |=> done && gstate == G_IDLE)
    else $error("burst did not end with done");
  a_stop_pattern: assert property ((seq_frame_last_byte and pattern == PAT_STOP
    && gen_enable && !start) |=> gstate == G_IDLE)
    else $error("generator ran past stop pattern");
  a_done_holds: assert property ((done && !done_read && !start) |=> done)
    else $error("done flag dropped without read");
  a_restart_reload: assert property (restart |=> !done || (!cont_mode
    && nfrm == 32'h0000_0000) ##0 remain == $past(nfrm))
    else $error("restart did not reload burst count");
  a_no_tick_without_clk: assert property ((!diag_clk_en) |-> !tick)
    else $error("generator ticked without diagnostic clock");
endmodule

/* shared/phy_fcg_pkg.sv */
// Package: register map, field layout, timing and carrier types of the frame check and generate block
package phy_fcg_pkg;
  // Timing: one byte at 10 Mb/s on a 50 MHz clock
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned BYTE_TIME_NS = 800;
  localparam int unsigned BYTE_CYCLES_INT = (BYTE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] BYTE_CYCLES = 6'(BYTE_CYCLES_INT);
  // Register indices (word addresses)
  localparam logic [15:0] REG_RX_ERR = 16'h8008;
  localparam logic [15:0] REG_FRM_H = 16'h8009;
  localparam logic [15:0] REG_FRM_L = 16'h800a;
  localparam logic [15:0] REG_OSZ = 16'h800e;
  localparam logic [15:0] REG_USZ = 16'h800f;
  localparam logic [15:0] REG_ODD = 16'h8010;
  localparam logic [15:0] REG_ODD_PRE = 16'h8011;
  localparam logic [15:0] REG_FALSE_CAR = 16'h8013;
  localparam logic [15:0] REG_GEN_EN = 16'h8020;
  localparam logic [15:0] REG_GEN_CTRL = 16'h8021;
  localparam logic [15:0] REG_GEN_CONT = 16'h8022;
  localparam logic [15:0] REG_GEN_IRQ_EN = 16'h8023;
  localparam logic [15:0] REG_PAY_LEN = 16'h8025;
  localparam logic [15:0] REG_IFG = 16'h8026;
  localparam logic [15:0] REG_NFRM_H = 16'h8027;
  localparam logic [15:0] REG_NFRM_L = 16'h8028;
  localparam logic [15:0] REG_DONE = 16'h8029;
  localparam logic [15:0] REG_DIAG_CLK = 16'h8030;
  // Field positions and reset values
  localparam int unsigned RESTART_BIT = 3;
  localparam logic [2:0] PATTERN_RST = 3'h1;
  localparam logic [15:0] PAY_LEN_RST = 16'h006b;
  localparam logic [15:0] IFG_RST = 16'h000c;
  localparam logic [31:0] NFRM_RST = 32'h0000_0100;
  localparam logic [15:0] SNAP_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  // Payload pattern codes
  localparam logic [2:0] PAT_STOP = 3'h0;
  localparam logic [2:0] PAT_RANDOM = 3'h1;
  localparam logic [2:0] PAT_ZEROS = 3'h2;
  localparam logic [2:0] PAT_ONES = 3'h3;
  localparam logic [2:0] PAT_ALT = 3'h4;
  localparam logic [2:0] PAT_DOWN = 3'h5;
  localparam logic [7:0] BYTE_ZEROS = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] BYTE_ALT = 8'h55;
  localparam logic [7:0] COUNTDOWN_TOP = 8'hff;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  // Frame layout
  localparam logic [15:0] OVERSIZE_BYTES = 16'h05f2;
  localparam logic [15:0] UNDERSIZE_BYTES = 16'h0040;
  localparam logic [15:0] PREAMBLE_LAST = 16'h0007;
  localparam logic [15:0] DEST_LAST = 16'h0005;
  localparam logic [15:0] SRC_LAST = 16'h000b;
  localparam logic [15:0] LEN_HI_IDX = 16'h000c;
  localparam logic [15:0] HEADER_LAST = 16'h000d;
  localparam logic [15:0] FCS_LAST = 16'h0003;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hd5;
  localparam logic [3:0] SFD_NIBBLE = 4'hd;
  localparam logic [7:0] DEST_BYTE = 8'hff;
  localparam logic [7:0] SRC_BYTE = 8'h02;  // Arbitrary value
  localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
  localparam logic [31:0] CRC_POLY = 32'hedb8_8320;
  localparam int unsigned NUM_ERR = 5;
  typedef struct packed {logic read; logic write; logic [15:0] address; logic [15:0] writedata;} av_req_t;
  typedef struct packed {logic en; logic [7:0] data;} tx_byte_t;
  typedef struct packed {logic dv; logic [3:0] nibble; logic bad_ssd;} rx_nibble_t;
endpackage

/* verilog/payload_pattern_source.sv */
// Payload byte source: random, fixed and countdown patterns for the frame generator
`timescale 1ns/1ps
module payload_pattern_source
  import phy_fcg_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic frame_start,
  input wire logic advance,
  input wire logic [2:0] pattern,
  output logic [7:0] pay_byte
);
  logic [15:0] lfsr;
  logic [15:0] next_lfsr;
  logic [7:0] down;
  logic [7:0] next_down;

  always_comb begin
    next_lfsr = lfsr;
    next_down = down;
    if (frame_start) begin
      next_down = COUNTDOWN_TOP;
    end else if (advance) begin
      next_down = down - 8'h01;
      next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lfsr <= LFSR_SEED;
      down <= COUNTDOWN_TOP;
    end else begin
      lfsr <= next_lfsr;
      down <= next_down;
    end
  end

  always_comb begin
    case (pattern)
      PAT_RANDOM: pay_byte = lfsr[7:0];
      PAT_ZEROS: pay_byte = BYTE_ZEROS;
      PAT_ONES: pay_byte = BYTE_ONES;
      PAT_ALT: pay_byte = BYTE_ALT;
      PAT_DOWN: pay_byte = down;
      default: pay_byte = BYTE_ZEROS;
    endcase
  end

  a_countdown_start: assert property (@(posedge clk) disable iff (!rstn)
    frame_start |=> (down == COUNTDOWN_TOP))
    else $error("countdown not reloaded to 255");
  a_countdown_step: assert property (@(posedge clk) disable iff (!rstn)
    (advance && !frame_start) |=> (down == $past(down) - 8'h01))
    else $error("countdown did not step down");
  a_fixed_patterns: assert property (@(posedge clk) disable iff (!rstn)
    (pattern == PAT_ALT) |-> (pay_byte == BYTE_ALT))
    else $error("alternating pattern wrong");
endmodule

/* bench/far_end_model.sv */
// Far-end model: receive nibble frames and false-carrier pulses
`timescale 1ns/1ps
module far_end_model
  import phy_fcg_pkg::*;
(
  input wire logic clk,
  output rx_nibble_t rx
);
  initial rx = '0;
  task automatic send(input int pre, input int dat);
    logic [3:0] n;
    for (int i = 0; i < pre + dat; i++) begin
      @(posedge clk);
      n = (i < pre - 1) ? 4'h5 : (i == pre - 1) ? SFD_NIBBLE : 4'(i);
      rx <= '{1'b1, n, 1'b0};
    end
    @(posedge clk);
    rx <= '{1'b0, ~n, 1'b0};
  endtask
  task automatic bad_ssd();
    @(posedge clk);
    rx.bad_ssd <= 1'b1;
    @(posedge clk);
    rx.bad_ssd <= 1'b0;
  endtask
endmodule

/* bench/test_phy_frame_check_and_generate.sv */
// Testbench: checker snapshots, generated frames and MAC pass-through
`timescale 1ns/1ps
module test_phy_frame_check_and_generate
  import phy_fcg_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  av_req_t av_req = '0;
  tx_byte_t mac_tx = '0;
  tx_byte_t phy_tx;
  tx_byte_t nv;
  tx_byte_t pv;
  rx_nibble_t rx;
  logic [15:0] av_readdata;
  logic [15:0] rs;
  logic [15:0] rdata;
  logic av_waitrequest;
  logic ws;
  logic gen_irq;
  logic [19:0] lf = 20'h17cb9;
  logic [7:0] gq[$];
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int ec = 0;
  int m[5] = '{default: 0};
  int pt[4] = '{16, 16, 16, 15};
  int dt[4] = '{20, 3046, 141, 140};
  logic [15:0] ra[12] = '{REG_OSZ, REG_USZ, REG_ODD, REG_ODD_PRE, REG_FALSE_CAR, REG_GEN_EN,
    REG_GEN_CTRL, REG_GEN_CONT, REG_NFRM_L, REG_PAY_LEN, REG_IFG, 16'h8001};
  logic [15:0] rv[12] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1, 16'h0, 16'h0100,
    16'h006b, 16'h000c, 16'h0};
  phy_frame_check_and_generate u_phy_frame_check_and_generate (.clk(clk), .rstn(rstn),
    .av_req(av_req), .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
    .rx_in(rx), .mac_tx(mac_tx), .phy_tx(phy_tx), .gen_irq(gen_irq));
  far_end_model u_far (.clk(clk), .rx(rx));
  initial forever #10 clk = ~clk;
  always @(negedge clk) begin
    ws = av_waitrequest;
    rs = av_readdata;
  end
  // Capture each generated byte in the first cycle it stands; a burst's last byte stands one cycle
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      wrap_up();
    end
    if (phy_tx.en === 1'b1) begin
      ec++;
      if (ec % 40 == 1) gq.push_back(phy_tx.data);
    end else ec = 0;
  end
  function automatic logic [19:0] rnd();
    lf = {lf[18:0], lf[19] ^ lf[16]};
    return lf;
  endfunction
  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
    av_req <= '{~w, w, a, d};
    do @(posedge clk); while (ws !== 1'b0);
    rdata = rs;
    av_req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0);
    chk(rdata, e);
  endtask
  task automatic run(input logic [15:0] a, input logic [15:0] d, input int nf, input int pat);
    gq.delete();
    bus(1'b1, a, d);
    for (int i = 0; i < 9000 && gen_irq !== 1'b1; i++) @(posedge clk);
    repeat (60) @(posedge clk);
    chk({15'h0, gen_irq}, 16'h1);
    chk(16'(gq.size()), 16'(nf * 30));
    for (int f = 0; f < nf * 30 && f < gq.size(); f += 30) begin
      chk({8'h0, gq[f + 7]}, {8'h0, SFD_BYTE});
      chk({gq[f + 20], gq[f + 21]}, 16'h0004);
      for (int k = 0; k < 4; k++)
        chk({8'h0, gq[f + 22 + k]}, {8'h0, pat == 5 ? 8'(255 - k) : 8'h55});
    end
    rd(REG_DONE, 16'h1);
    rd(REG_DONE, 16'h0);
    chk({15'h0, gen_irq}, 16'h0);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (ra[i]) rd(ra[i], rv[i]);
    foreach (pt[i]) begin
      u_far.send(pt[i], dt[i]);
      repeat (4) @(posedge clk);
      if (dt[i] / 2 > 1522) m[0]++;
      if (dt[i] / 2 < 64) m[1]++;
      if (dt[i] % 2) m[2]++;
      if (pt[i] % 2) m[3]++;
    end
    repeat (2) begin
      u_far.bad_ssd();
      m[4]++;
    end
    repeat (2) @(posedge clk);
    rd(REG_OSZ, 16'h0);
    bus(1'b0, REG_RX_ERR, 16'h0);
    chk(rdata, 16'(m[0] + m[1] + m[2] + m[3] + m[4]));
    for (int i = 0; i < 5; i++) rd(ra[i], 16'(m[i]));
    rd(REG_RX_ERR, 16'h0);
    rd(REG_FRM_L, 16'h0004);
    bus(1'b1, REG_DIAG_CLK, 16'h1);
    bus(1'b1, REG_GEN_IRQ_EN, 16'h1);
    bus(1'b1, REG_PAY_LEN, 16'h4);
    bus(1'b1, REG_IFG, 16'h2);
    bus(1'b1, REG_NFRM_H, 16'h0);
    bus(1'b1, REG_NFRM_L, 16'h2);
    bus(1'b1, REG_GEN_CTRL, 16'h5);
    run(REG_GEN_EN, 16'h1, 2, 5);
    bus(1'b1, REG_NFRM_L, 16'h1);
    run(REG_GEN_CTRL, 16'h000c, 1, 4);
    rd(REG_GEN_CTRL, 16'h0004);
    bus(1'b1, REG_GEN_CONT, 16'h1);
    gq.delete();
    bus(1'b1, REG_GEN_CTRL, 16'h000b);
    for (int i = 0; i < 9000 && gq.size() < 75; i++) @(posedge clk);
    bus(1'b1, REG_GEN_CTRL, 16'h0000);
    repeat (2000) @(posedge clk);
    chk(16'(gq.size()), 16'h005a);
    chk({gq[22], gq[55]}, {BYTE_ONES, BYTE_ONES});
    rd(REG_DONE, 16'h0);
    bus(1'b1, REG_GEN_EN, 16'h0);
    pv = mac_tx;
    repeat (20) begin
      nv = 9'(rnd());
      mac_tx <= nv;
      @(negedge clk);
      chk({7'h0, phy_tx}, {7'h0, pv});
      pv = nv;
      @(posedge clk);
    end
    wrap_up();
  end
endmodule
